// File: core/vtpd_pkg.sv
// Package with constants and carrier types for the period/duty compare registers.
package vtpd_pkg;
   localparam int unsigned VTPD_NUM_SUB = 4;
   localparam int unsigned VTPD_DW = 16;
   localparam int unsigned VTPD_AW = 4;
   // Word indices of the register file; byte address is twice the index.
   localparam logic [3:0] VTPD_IDX_PER0 = 4'h0;
   localparam logic [3:0] VTPD_IDX_DTY0 = 4'h4;
   localparam logic [15:0] VTPD_RST_VAL = 16'h0000;
   localparam logic [15:0] VTPD_CNT_ZERO = 16'h0000;
   localparam logic [15:0] VTPD_CNT_ONE = 16'h0001;

   typedef enum logic {VTPD_MODE_PWM, VTPD_MODE_CAP} vtpd_mode_e;

   // Register bus request, word wide, word index addressing.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] idx;
      logic [15:0] wdata;
   } vtpd_req_s;

   // Per-subsystem view of the counter side.
   typedef struct packed {
      logic [15:0] count;
      logic [1:0] run;
      vtpd_mode_e mode;
      logic polarity;
      logic per_cap;
      logic dty_cap;
   } vtpd_cnt_s;

   // State of one compare channel.
   typedef struct packed {
      logic [15:0] per_buf;
      logic [15:0] per_act;
      logic [15:0] dty_buf;
      logic [15:0] dty_act;
      logic pwm;
      logic [15:0] cnt_prev;
   } vtpd_ch_s;
endpackage : vtpd_pkg

// File: core/vtpd_chan.sv
// One timer subsystem: double-buffered period and duty compare values.
`timescale 1ns/10ps
`default_nettype none
module vtpd_chan (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wr_per,
   input wire logic wr_dty,
   input wire logic [15:0] wdata,
   input wire vtpd_pkg::vtpd_cnt_s cnt,
   output logic [15:0] per_value,
   output logic [15:0] dty_value,
   output logic [15:0] per_active,
   output logic [15:0] dty_active,
   output logic period_match,
   output logic pwm_out
);
   import vtpd_pkg::*;
   vtpd_ch_s s_q, s_d;
   logic stopped;
   logic boundary;
   logic out_raw;

   always_comb begin
      s_d = s_q;
      // Stopped when both run bits clear.
      stopped = (cnt.run == 2'b00);
      boundary = (cnt.count == s_q.per_act);
      out_raw = s_q.pwm;
      if (cnt.mode == VTPD_MODE_PWM) begin
         if (wr_per) begin
            s_d.per_buf = wdata;
         end
         if (wr_dty) begin
            s_d.dty_buf = wdata;
         end
         if (stopped || boundary) begin
            s_d.per_act = wr_per ? wdata : s_q.per_buf;
            s_d.dty_act = wr_dty ? wdata : s_q.dty_buf;
         end
         // Rise on 00h to 01h, fall on duty match.
         if (!stopped && s_q.cnt_prev == VTPD_CNT_ZERO &&
             cnt.count == VTPD_CNT_ONE) begin
            out_raw = 1'b1;
         end else if (cnt.count == s_q.dty_act) begin
            out_raw = 1'b0;
         end
         s_d.pwm = out_raw;
      end else begin
         // Software writes still land in capture mode.
         if (wr_per) begin
            s_d.per_buf = wdata;
            s_d.per_act = wdata;
         end
         if (wr_dty) begin
            s_d.dty_buf = wdata;
            s_d.dty_act = wdata;
         end
         // A capture wins over a same-cycle write.
         if (cnt.per_cap) begin
            s_d.per_buf = cnt.count;
            s_d.per_act = cnt.count;
         end
         if (cnt.dty_cap) begin
            s_d.dty_buf = cnt.count;
            s_d.dty_act = cnt.count;
         end
      end
      s_d.cnt_prev = cnt.count;
   end

   always_ff @(posedge clk or negedge nrst) begin
      // Clear all on reset, pending values too.
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Reads return the buffered value: the latest write or capture.
   assign per_value = s_q.per_buf;
   assign dty_value = s_q.dty_buf;
   assign per_active = s_q.per_act;
   assign dty_active = s_q.dty_act;
   assign period_match = (cnt.count == s_q.per_act);
   assign pwm_out = s_q.pwm ^ cnt.polarity;

   // Pending period reaches active at stop.
   stop_load_a: assert property (@(posedge clk) disable iff (!nrst)
      (cnt.mode == VTPD_MODE_PWM && cnt.run == 2'b00 && !wr_per)
      |=> per_active == $past(per_value))
      else $error("period not loaded while stopped");
   // Duty does not change mid period while running.
   duty_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (cnt.mode == VTPD_MODE_PWM && cnt.run != 2'b00 &&
       cnt.count != per_active) |=> $stable(dty_active))
      else $error("duty changed away from boundary");
   // Write is visible on read next cycle.
   read_back_a: assert property (@(posedge clk) disable iff (!nrst)
      (wr_per && cnt.mode == VTPD_MODE_PWM) |=> per_value == $past(wdata))
      else $error("period readback wrong");
   cap_load_a: assert property (@(posedge clk) disable iff (!nrst)
      (cnt.mode == VTPD_MODE_CAP && cnt.dty_cap)
      |=> dty_value == $past(cnt.count))
      else $error("capture not loaded");
endmodule : vtpd_chan
`default_nettype wire

// File: core/vtpd_regs.sv
// Top: four period/capture and four duty/capture registers with PWM compare.
`timescale 1ns/10ps
`default_nettype none
module vtpd_regs #(
   parameter int unsigned NUM_SUB = vtpd_pkg::VTPD_NUM_SUB
) (
   input wire logic clk,
   input wire logic nrst,
   input wire vtpd_pkg::vtpd_req_s req,
   output logic [15:0] rdata,
   input wire vtpd_pkg::vtpd_cnt_s [NUM_SUB-1:0] cnt,
   output logic [NUM_SUB-1:0] period_match,
   output logic [NUM_SUB-1:0] pwm_out,
   output logic [NUM_SUB*16-1:0] per_active,
   output logic [NUM_SUB*16-1:0] dty_active
);
   import vtpd_pkg::*;

   // ************************************************************
   // Per-subsystem channels
   // ************************************************************
   logic [15:0] per_val [NUM_SUB];
   logic [15:0] dty_val [NUM_SUB];
   logic [15:0] rdata_d;
   logic [15:0] rdata_q;

   function automatic logic hit(input logic [3:0] idx, input logic [3:0] base,
                                input int unsigned n);
      hit = (idx == 4'(base + n));
   endfunction : hit

   genvar g;
   generate
      for (g = 0; g < NUM_SUB; g++) begin : g_ch
         // One pair of registers per subsystem.
         vtpd_chan vtpd_chan_i (
            .clk(clk),
            .nrst(nrst),
            .wr_per(req.wr && hit(req.idx, VTPD_IDX_PER0, g)),
            .wr_dty(req.wr && hit(req.idx, VTPD_IDX_DTY0, g)),
            .wdata(req.wdata),
            .cnt(cnt[g]),
            .per_value(per_val[g]),
            .dty_value(dty_val[g]),
            .per_active(per_active[g*16 +: 16]),
            .dty_active(dty_active[g*16 +: 16]),
            .period_match(period_match[g]),
            .pwm_out(pwm_out[g])
         );
      end
   endgenerate

   // ************************************************************
   // Read path
   // ************************************************************
   always_comb begin
      rdata_d = rdata_q;
      if (req.rd) begin
         rdata_d = VTPD_RST_VAL;
         for (int i = 0; i < NUM_SUB; i++) begin
            // Return buffered value, not the active one.
            if (hit(req.idx, VTPD_IDX_PER0, i)) begin
               rdata_d = per_val[i];
            end
            if (hit(req.idx, VTPD_IDX_DTY0, i)) begin
               rdata_d = dty_val[i];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= VTPD_RST_VAL;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;

   // Reset leaves every read at zero.
   reset_zero_a: assert property (@(posedge clk)
      $rose(nrst) |-> rdata == VTPD_RST_VAL)
      else $error("read data not cleared by reset");
   // Duty value of subsystem 0 is zero after reset.
   duty_reset_a: assert property (@(posedge clk)
      $rose(nrst) |-> dty_val[0] == VTPD_RST_VAL)
      else $error("duty not cleared by reset");
   // Duty read returns subsystem 0 duty register.
   duty_read_a: assert property (@(posedge clk) disable iff (!nrst)
      (req.rd && req.idx == VTPD_IDX_DTY0) |=> rdata == $past(dty_val[0]))
      else $error("duty read mismatch");
   stop_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
      (cnt[0].run == 2'b00 && cnt[0].mode == VTPD_MODE_PWM)
      |=> (pwm_out[0] ^ cnt[0].polarity) <=
          $past(pwm_out[0] ^ cnt[0].polarity))
      else $error("output rose while stopped");
endmodule : vtpd_regs
`default_nettype wire

// File: tb/vtpd_regs_tb_top.sv
// Self-checking bench for the period/duty compare register top.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module vtpd_regs_tb_top;
   import vtpd_pkg::*;
   logic clk;
   logic nrst;
   vtpd_req_s req;
   logic [15:0] rdata;
   vtpd_cnt_s [3:0] cnt;
   logic [3:0] period_match;
   logic [3:0] pwm_out;
   logic [63:0] per_active;
   logic [63:0] dty_active;
   logic [15:0] exp_q[$];
   logic [15:0] exp_v;
   logic [15:0] pv[4];
   logic [15:0] v;
   logic [15:0] w;
   logic [31:0] seed = 32'h5F26;
   logic rd_p;
   int num_errors = 0;
   int checks = 0;

   vtpd_regs #(.NUM_SUB(4)) vtpd_regs_i (.clk(clk), .nrst(nrst), .req(req),
      .rdata(rdata), .cnt(cnt), .period_match(period_match),
      .pwm_out(pwm_out), .per_active(per_active), .dty_active(dty_active));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction : rnd

   // Reads note their expected value; the monitor pops it one cycle later.
   // Every access is one full word at a register's own index.
   task op(input logic rd, input logic wr, input logic [3:0] idx,
           input logic [15:0] d);
      @(negedge clk);
      req = '{rd: rd, wr: wr, idx: idx, wdata: d};
      if (rd) exp_q.push_back(d);
   endtask : op

   task idle();
      @(negedge clk);
      req = '0;
   endtask : idle

   task results();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results

   always @(posedge clk) rd_p <= req.rd;
   always @(negedge clk) if (rd_p === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
   end

   // A hung run is cut short well past the expected run of under a hundred cycles.
   initial begin
      #200000;
      num_errors++;
      results();
   end

   initial begin
      nrst = 1'b0;
      req = '0;
      cnt = '0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      for (int i = 0; i < 8; i++) op(1'b1, 1'b0, i[3:0], 16'h0000);
      `CHK(per_active, 64'h0)
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         pv[i] = v;
         op(1'b0, 1'b1, i[3:0], v);
         op(1'b0, 1'b1, i[3:0] + 4'h4, ~v);
         op(1'b1, 1'b0, i[3:0], v);
         op(1'b1, 1'b0, i[3:0] + 4'h4, ~v);
         `CHK(per_active[i*16+:16], v)
         `CHK(dty_active[i*16+:16], ~v)
      end
      idle();
      for (int i = 0; i < 4; i++) begin
         w = rnd();
         // One run bit alone already counts as running.
         cnt[i].run = (i % 2) ? 2'b01 : 2'b10;
         cnt[i].count = pv[i] + 16'h0001;
         op(1'b0, 1'b1, i[3:0], w);
         op(1'b0, 1'b1, i[3:0] + 4'h4, ~w);
         op(1'b1, 1'b0, i[3:0], w);
         idle();
         `CHK(per_active[i*16+:16], pv[i])
         `CHK(dty_active[i*16+:16], ~pv[i])
         cnt[i].count = pv[i];
         #1 `CHK(period_match[i], 1'b1)
         @(negedge clk);
         `CHK(per_active[i*16+:16], w)
         `CHK(dty_active[i*16+:16], ~w)
         cnt[i].run = 2'b00;
         cnt[i].mode = VTPD_MODE_CAP;
         cnt[i].count = w ^ 16'h00FF;
         cnt[i].per_cap = 1'b1;
         @(negedge clk);
         cnt[i].per_cap = 1'b0;
         cnt[i].dty_cap = 1'b1;
         cnt[i].count = ~w;
         @(negedge clk);
         cnt[i].dty_cap = 1'b0;
         cnt[i].mode = VTPD_MODE_PWM;
         op(1'b1, 1'b0, i[3:0], w ^ 16'h00FF);
         op(1'b1, 1'b0, i[3:0] + 4'h4, ~w);
         idle();
         pv[i] = w;
      end
      op(1'b0, 1'b1, 4'h1, rnd());
      op(1'b1, 1'b0, 4'h4, ~pv[0]);
      op(1'b1, 1'b0, 4'h5, ~pv[1]);
      op(1'b0, 1'b1, 4'h0, 16'h000A);
      op(1'b0, 1'b1, 4'h4, 16'h0003);
      idle();
      cnt[0].run = 2'b01;
      cnt[0].count = 16'h0000;
      @(negedge clk) cnt[0].count = 16'h0001;
      @(negedge clk) cnt[0].count = 16'h0002;
      `CHK(pwm_out[0], 1'b1)
      @(negedge clk) cnt[0].count = 16'h0003;
      @(negedge clk) `CHK(pwm_out[0], 1'b0)
      cnt[0].polarity = 1'b1;
      #1 `CHK(pwm_out[0], 1'b1)
      results();
   end
endmodule : vtpd_regs_tb_top
`default_nettype wire
